// ===== hw/usst_pkg.sv
package usst_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int          DATA_W         = 8;
    localparam int          CNT_W          = 4;

    // ----------------------------------------------------------------
    // status word layout
    // ----------------------------------------------------------------
    localparam int          STAT_START_BIT = 7;
    localparam int          STAT_OVF_BIT   = 6;
    localparam int          STAT_CNT_LSB   = 0;

    // ----------------------------------------------------------------
    // wire modes
    // ----------------------------------------------------------------
    localparam logic [1:0]  WM_NONE        = 2'h0;
    localparam logic [1:0]  WM_THREE       = 2'h1;
    localparam logic [1:0]  WM_TWO         = 2'h2;
    localparam logic [1:0]  WM_TWO_HOLD    = 2'h3;

    // ----------------------------------------------------------------
    // reset values and counter limits
    // ----------------------------------------------------------------
    localparam logic [7:0]  DATA_RST       = 8'h00;
    localparam logic [3:0]  CNT_RST        = 4'h0;
    localparam logic [3:0]  CNT_MAX        = 4'hf;
    localparam logic [3:0]  CNT_ONE        = 4'h1;

endpackage

// ===== hw/usst_sync_if.sv
`timescale 1ns/1ns
interface usst_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] lvl;
    logic [W-1:0] chg;

    modport src (output raw, input lvl, input chg);
    modport dst (input raw, output lvl, output chg);
endinterface

// ===== hw/usst_sync.sv
`timescale 1ns/1ns
module usst_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic   ref_clk_i,
    input  wire logic   arst_n_i,
    // crossing
    usst_sync_if.dst    port
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // ----------------------------------------------------------------
    // two-stage synchroniser, third stage only for change detect
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= port.raw;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign port.lvl = sync_q;
    assign port.chg = sync_q ^ prev_q;
endmodule

// ===== hw/usst_top.sv
`timescale 1ns/1ns
//Contract
// - one 8-bit shift register, directly accessible, mirrored into a buffer register
// - register msb reaches a mode-selected pin through a latch, opposite to sampling
// - serial input always comes from the data-input pin
// - 4-bit counter readable and writable, can raise an overflow interrupt
// - shift register and counter run from the same selected clock source, except external clock with software strobe: counter counts toggle writes
// - external clock advances the counter on both edges while the software strobe is clear
// - clock source: external pin, timer 0 compare match, or software strobe
// - two-wire clock unit: start interrupt, holds clock low after start, and after overflow in hold mode only
// - three-wire behaves as serial-peripheral modes 0 and 1, no hardware select
// - master and slave registers fully exchanged after eight clock cycles
// - edge select 0: sample on rising, shift and change output on falling
// - edge select 1: sample on falling, shift and change output on rising
// - sixteen counted edges overflow the counter and set the overflow flag
// - overflow interrupt can wake the processor from idle sleep
// - status write with flag bit one clears flag and loads the counter
// - toggle write in software-count mode toggles clock pin and advances counter
// - master clock up to half system clock by alternating control writes
// - buffer register takes shift register contents when a transfer completes
// - a write and a clock edge together keep the written value, no shift
// - latch open first half-cycle with external clock, always open internally
module usst_top
    import usst_pkg::*;
(
    // clocks and reset
    input  wire logic               ref_clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               link_clk_i,
    // configuration
    input  wire logic [1:0]         wire_mode_i,
    input  wire logic               external_clock_select_i,
    input  wire logic               clock_edge_select_i,
    input  wire logic               software_shift_strobe_i,
    input  wire logic               ovf_int_en_i,
    input  wire logic               start_int_en_i,
    // software writes
    input  wire logic               ctrl_we_i,
    input  wire logic               clock_toggle_strobe_i,
    input  wire logic               data_we_i,
    input  wire logic [DATA_W-1:0]  data_wdata_i,
    input  wire logic               stat_we_i,
    input  wire logic [DATA_W-1:0]  stat_wdata_i,
    // timer event
    input  wire logic               timer0_match_i,
    // pins
    input  wire logic               serial_data_in_i,
    input  wire logic               data_out_dir_i,
    input  wire logic               sda_dir_i,
    input  wire logic               sck_dir_i,
    output logic                    data_out_o,
    output logic                    data_out_oe_o,
    output logic                    sda_o,
    output logic                    sda_oe_o,
    output logic                    sck_o,
    output logic                    sck_oe_o,
    // readback and interrupts
    output logic [DATA_W-1:0]       shift_data_o,
    output logic [DATA_W-1:0]       shift_buffer_o,
    output logic [CNT_W-1:0]        counter_o,
    output logic [DATA_W-1:0]       status_o,
    output logic                    ovf_int_o,
    output logic                    start_int_o
);

    // ----------------------------------------------------------------
    // link domain: capture input on each serial clock edge
    // ----------------------------------------------------------------
    logic rise_tgl_q;
    logic rise_bit_q;
    logic fall_tgl_q;
    logic fall_bit_q;

    // input is caught in the link domain, so no system-clock skew on it
    always_ff @(posedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rise_tgl_q <= 1'b0;
            rise_bit_q <= 1'b0;
        end else begin
            rise_tgl_q <= ~rise_tgl_q;
            rise_bit_q <= serial_data_in_i;
        end
    end

    always_ff @(negedge link_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fall_tgl_q <= 1'b0;
            fall_bit_q <= 1'b0;
        end else begin
            fall_tgl_q <= ~fall_tgl_q;
            fall_bit_q <= serial_data_in_i;
        end
    end

    // ----------------------------------------------------------------
    // crossings into the system domain
    // ----------------------------------------------------------------
    usst_sync_if #(.W(2)) edge_if ();
    usst_sync_if #(.W(3)) pin_if ();

    assign edge_if.raw = {fall_tgl_q, rise_tgl_q};
    assign pin_if.raw  = {link_clk_i, serial_data_in_i, 1'b0};

    usst_sync #(.W(2)) u_edge_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .port      (edge_if)
    );

    usst_sync #(.W(3)) u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .port      (pin_if)
    );

    logic rise_p;
    logic fall_p;
    logic din_s;
    logic sck_s;
    logic din_fall_p;

    assign rise_p     = edge_if.chg[0];
    assign fall_p     = edge_if.chg[1];
    assign sck_s      = pin_if.lvl[2];
    assign din_s      = pin_if.lvl[1];
    assign din_fall_p = pin_if.chg[1] & ~pin_if.lvl[1];

    // ----------------------------------------------------------------
    // clock source selection
    // ----------------------------------------------------------------
    logic sw_toggle;
    logic sample_p;
    logic shift_p;
    logic cnt_p;
    logic shift_bit;

    assign sw_toggle = ctrl_we_i & clock_toggle_strobe_i;
    // edge select picks which edge samples and which shifts
    assign sample_p  = clock_edge_select_i ? fall_p : rise_p;

    always_comb begin
        shift_p   = 1'b0;
        cnt_p     = 1'b0;
        shift_bit = din_s;
        if (external_clock_select_i) begin
            shift_p   = clock_edge_select_i ? rise_p : fall_p;
            shift_bit = clock_edge_select_i ? fall_bit_q : rise_bit_q;
            if (software_shift_strobe_i) begin
                cnt_p = sw_toggle;
            end else begin
                cnt_p = rise_p | fall_p;
            end
        end else if (clock_edge_select_i) begin
            shift_p = timer0_match_i;
            cnt_p   = timer0_match_i;
        end else begin
            shift_p = ctrl_we_i & software_shift_strobe_i;
            cnt_p   = shift_p;
        end
    end

    // ----------------------------------------------------------------
    // shift register and buffer
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] data_d;
    logic [DATA_W-1:0] buf_q;
    logic              wrap_p;

    always_comb begin
        data_d = data_q;
        if (data_we_i) begin
            data_d = data_wdata_i;
        end else if (shift_p) begin
            data_d = {data_q[DATA_W-2:0], shift_bit};
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_q <= DATA_RST;
        end else begin
            data_q <= data_d;
        end
    end

    // buffer frees software from reading the live register in time
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            buf_q <= DATA_RST;
        end else if (wrap_p) begin
            buf_q <= data_d;
        end
    end

    // ----------------------------------------------------------------
    // edge counter and overflow flag
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt_q;
    logic             ovf_q;

    assign wrap_p = cnt_p & ~stat_we_i & (cnt_q == CNT_MAX);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= CNT_RST;
        end else if (stat_we_i) begin
            cnt_q <= stat_wdata_i[STAT_CNT_LSB +: CNT_W];
        end else if (cnt_p) begin
            cnt_q <= cnt_q + CNT_ONE;
        end
    end

    // a counted edge in the clearing cycle is dropped: the status write blocks the wrap
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ovf_q <= 1'b0;
        end else if (wrap_p) begin
            ovf_q <= 1'b1;
        end else if (stat_we_i && stat_wdata_i[STAT_OVF_BIT]) begin
            ovf_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // two-wire start detector and clock hold (overview only)
    // ----------------------------------------------------------------
    logic start_q;
    logic two_wire;
    logic hold_q;

    assign two_wire = wire_mode_i[1];

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            start_q <= 1'b0;
        end else if (two_wire && din_fall_p && sck_s) begin
            start_q <= 1'b1;
        end else if (stat_we_i && stat_wdata_i[STAT_START_BIT]) begin
            start_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hold_q <= 1'b0;
        end else begin
            hold_q <= two_wire & (start_q | ((wire_mode_i == WM_TWO_HOLD) & ovf_q));
        end
    end

    // ----------------------------------------------------------------
    // output latch and clock pin
    // ----------------------------------------------------------------
    logic latch_open_q;
    logic out_q;
    logic sck_port_q;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            latch_open_q <= 1'b1;
        end else if (!external_clock_select_i || shift_p) begin
            latch_open_q <= 1'b1;
        end else if (sample_p) begin
            latch_open_q <= 1'b0;
        end
    end

    // one cycle late against the register: the price of a flopped pin
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_q <= 1'b0;
        end else if (latch_open_q || !external_clock_select_i) begin
            out_q <= data_q[DATA_W-1];
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_port_q <= 1'b0;
        end else if (sw_toggle) begin
            sck_port_q <= ~sck_port_q;
        end
    end

    // no select pin: framing is software's job
    assign data_out_o    = out_q;
    assign data_out_oe_o = data_out_dir_i & (wire_mode_i == WM_THREE);
    assign sda_o         = 1'b0;
    assign sda_oe_o      = two_wire & sda_dir_i & ~out_q;
    assign sck_o         = sck_port_q & ~hold_q;
    assign sck_oe_o      = sck_dir_i | hold_q;

    // ----------------------------------------------------------------
    // readback and interrupts
    // ----------------------------------------------------------------
    assign shift_data_o   = data_q;
    assign shift_buffer_o = buf_q;
    assign counter_o      = cnt_q;
    assign status_o       = {start_q, ovf_q, 2'h0, cnt_q};
    // level output, also serves as idle wake-up request
    assign ovf_int_o      = ovf_q & ovf_int_en_i;
    assign start_int_o    = start_q & start_int_en_i;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    AST_WRITE_WINS: assert property (
        data_we_i |=> data_q == $past(data_wdata_i))
        else $error("data write lost to a shift");

    AST_SHIFT_LEFT: assert property (
        shift_p && !data_we_i |=> data_q == {$past(data_q[6:0]), $past(shift_bit)})
        else $error("shift register did not shift left");

    AST_WRAP_FLAG: assert property (
        wrap_p |=> ovf_q && (cnt_q == CNT_RST))
        else $error("wrap did not set flag and zero counter");

    AST_BUFFER_COPY: assert property (
        wrap_p |=> shift_buffer_o == shift_data_o)
        else $error("buffer not loaded on transfer end");

    AST_STATUS_WRITE: assert property (
        stat_we_i && stat_wdata_i[STAT_OVF_BIT] && !wrap_p
        |=> !ovf_q && (cnt_q == $past(stat_wdata_i[3:0])))
        else $error("status write did not clear flag or load counter");

    AST_BOTH_EDGES: assert property (
        external_clock_select_i && !software_shift_strobe_i && (rise_p || fall_p)
        && !stat_we_i |=> cnt_q == $past(cnt_q) + CNT_ONE)
        else $error("external edge not counted");

    AST_TOGGLE_PIN: assert property (
        sw_toggle |=> sck_port_q != $past(sck_port_q))
        else $error("toggle write did not toggle clock pin");

    AST_OPEN_LATCH: assert property (
        !external_clock_select_i [*2] |-> out_q == $past(data_q[7]))
        else $error("latch not transparent under internal clock");

    AST_HOLD_EXT: assert property (
        external_clock_select_i && !latch_open_q && !shift_p |=> $stable(out_q))
        else $error("closed latch let output change");

    AST_FLAG_IRQ: assert property (
        wrap_p && ovf_int_en_i ##1 ovf_int_en_i |-> ovf_int_o)
        else $error("overflow did not raise interrupt");

endmodule

// ===== test/usst_partner.sv
`timescale 1ns/1ns
// --------------------------------
// far-side master, three-wire mode 0
// --------------------------------
module usst_partner (
    // link pins
    output logic        link_clk_o,
    output logic        sdi_o,
    input  wire logic   sdo_i,
    // received byte
    output logic [7:0]  rx_o
);
    // levels held long: the slave needs three system cycles per level
    localparam int HOLD = 5;
    logic grid;

    initial begin
        grid       = 1'b0;
        link_clk_o = 1'b0; // clock stands still outside frames
        sdi_o      = 1'b1;
        rx_o       = 8'h00;
        #7;
        forever #15 grid = ~grid;
    end

    task automatic level(input logic lvl);
        link_clk_o = lvl;
        repeat (HOLD) @(posedge grid);
    endtask

    task automatic exchange(input logic [7:0] tx);
        sdi_o = tx[7];
        repeat (HOLD) @(posedge grid);
        for (int i = 7; i >= 0; i--) begin
            rx_o = {rx_o[6:0], sdo_i};
            level(1'b1);
            // line released after the last bit shows the inverse
            sdi_o = (i > 0) ? tx[i-1] : ~tx[0];
            level(1'b0);
        end
    endtask
endmodule

// ===== test/usst_top_tb.sv
`timescale 1ns/1ns
module usst_top_tb;
    import usst_pkg::*;
    // --------------------------------
    // signals
    // --------------------------------
    typedef struct packed {
        logic [1:0] m;
        logic       di;
        logic [3:0] n;
        logic [7:0] d;
        logic [7:0] e;
        logic [3:0] c;
    } usst_row_t;
    logic        ref_clk_i, arst_n_i, link_clk_i, tb_di, p_sdi, use_p;
    logic [1:0]  wire_mode;
    logic        ext_sel, edge_sel, sw_strobe, ctrl_we, toggle, data_we, stat_we;
    logic        timer_m, data_out, data_out_oe, sck, sck_oe, ovf_int;
    logic        sda, sda_oe, start_int, sda_dir, sck_dir;
    logic [7:0]  wdata, shift_data, shift_buf, status, rx;
    logic [3:0]  counter;
    int          n_fail, checked, cyc;
    usst_row_t   rows [4] = '{
        '{2'h1, 1'b1, 4'h1, 8'ha5, 8'h4b, 4'h1},
        '{2'h0, 1'b0, 4'h3, 8'ha5, 8'h28, 4'h3},
        '{2'h2, 1'b1, 4'h8, 8'h81, 8'hff, 4'h8},
        '{2'h1, 1'b1, 4'h4, 8'h3c, 8'hcf, 4'h4}};

    usst_top i_dut (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .link_clk_i(link_clk_i),
        .wire_mode_i(wire_mode), .external_clock_select_i(ext_sel),
        .clock_edge_select_i(edge_sel), .software_shift_strobe_i(sw_strobe),
        .ovf_int_en_i(1'b1), .start_int_en_i(1'b1), .ctrl_we_i(ctrl_we),
        .clock_toggle_strobe_i(toggle), .data_we_i(data_we), .data_wdata_i(wdata),
        .stat_we_i(stat_we), .stat_wdata_i(wdata), .timer0_match_i(timer_m),
        .serial_data_in_i(use_p ? p_sdi : tb_di), .data_out_dir_i(1'b1),
        .sda_dir_i(sda_dir), .sck_dir_i(sck_dir), .data_out_o(data_out),
        .data_out_oe_o(data_out_oe), .sda_o(sda), .sda_oe_o(sda_oe), .sck_o(sck),
        .sck_oe_o(sck_oe), .shift_data_o(shift_data), .shift_buffer_o(shift_buf),
        .counter_o(counter), .status_o(status), .ovf_int_o(ovf_int),
        .start_int_o(start_int));

    usst_partner i_partner (
        .link_clk_o(link_clk_i), .sdi_o(p_sdi), .sdo_i(data_out), .rx_o(rx));

    // --------------------------------
    // helpers
    // --------------------------------
    always #10 ref_clk_i = ~ref_clk_i;

    task automatic complete_run();
        if (n_fail == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // generous ceiling: the whole run needs under three hundred cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // sel = {timer, ctrl, stat, data}; one-cycle strobes
    task automatic wr(input logic [3:0] sel, input logic [7:0] d);
        @(posedge ref_clk_i);
        {timer_m, ctrl_we, stat_we, data_we} <= sel;
        wdata <= d;
        toggle <= d[0];
        @(posedge ref_clk_i);
        {timer_m, ctrl_we, stat_we, data_we} <= 4'h0;
        #1;
    endtask

    task automatic cfg(input logic [1:0] m, input logic e, input logic s, input logic w);
        @(posedge ref_clk_i);
        wire_mode <= m;
        ext_sel <= e;
        edge_sel <= s;
        sw_strobe <= w;
    endtask

    // --------------------------------
    // tests
    // --------------------------------
    initial begin
        ref_clk_i = 1'b0;
        arst_n_i = 1'b0;
        {tb_di, use_p, ctrl_we, toggle, data_we, stat_we, timer_m, sda_dir, sck_dir} = 9'h000;
        {wire_mode, ext_sel, edge_sel, sw_strobe, wdata} = 13'h0000;
        n_fail = 0;
        checked = 0;
        cyc = 0;
        repeat (6) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        foreach (rows[i]) begin
            cfg(rows[i].m, 1'b0, 1'b0, 1'b1);
            tb_di <= rows[i].di;
            wr(4'h2, 8'h40);
            wr(4'h1, rows[i].d);
            repeat (rows[i].n) wr(4'h4, 8'h00);
            @(posedge ref_clk_i);
            #1;
            chk("shift", rows[i].e, shift_data);
            chk("count", {4'h0, rows[i].c}, {4'h0, counter});
            chk("dout", {7'h0, rows[i].e[7]}, {7'h0, data_out});
            chk("dout_oe", {7'h0, rows[i].m == 2'h1}, {7'h0, data_out_oe});
        end
        // counter at fifteen, one strobe completes the byte
        wr(4'h2, 8'h0f);
        wr(4'h1, 8'h5a);
        wr(4'h4, 8'h00);
        chk("ovf_buf", 8'hb5, shift_buf);
        chk("ovf_stat", 8'h40, status);
        chk("ovf_int", 8'h01, {7'h0, ovf_int});
        wr(4'h2, 8'h45);
        chk("clr_stat", 8'h05, status);
        chk("clr_int", 8'h00, {7'h0, ovf_int});
        // two-wire start: data line falls while the clock line is high
        cfg(2'h3, 1'b0, 1'b0, 1'b1);
        sda_dir <= 1'b1;
        wr(4'h1, 8'h00);
        i_partner.level(1'b1);
        @(posedge ref_clk_i);
        tb_di <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        #1;
        chk("start", 8'hb4, {status[7], sda, sda_oe, start_int, sck, sck_oe, 2'h0});
        wr(4'h2, 8'h8f);
        chk("start_clr", 8'h00, {status[7], 6'h0, start_int});
        // hold mode: overflow pulls the clock line low
        wr(4'h4, 8'h00);
        @(posedge ref_clk_i);
        #1;
        chk("ovf_hold", 8'h01, {6'h0, sck, sck_oe});
        i_partner.level(1'b0);
        @(posedge ref_clk_i);
        tb_di <= 1'b1;
        wr(4'h2, 8'h45);
        cfg(2'h1, 1'b0, 1'b1, 1'b0);
        wr(4'h1, 8'h01);
        wr(4'h8, 8'h00);
        chk("tmr_shift", 8'h03, shift_data);
        chk("tmr_count", 8'h06, {4'h0, counter});
        cfg(2'h1, 1'b0, 1'b0, 1'b1);
        wr(4'h5, 8'h32);
        chk("collide", 8'h32, shift_data);
        cfg(2'h1, 1'b1, 1'b0, 1'b1);
        sck_dir <= 1'b1;
        wr(4'h2, 8'h40);
        wr(4'h4, 8'h01);
        chk("sck_hi", 8'h03, {6'h0, sck, sck_oe});
        wr(4'h4, 8'h01);
        chk("sck_lo", 8'h01, {6'h0, sck, sck_oe});
        chk("tgl_count", 8'h02, {4'h0, counter});
        // external clock, full byte swap with the far side
        cfg(2'h1, 1'b1, 1'b0, 1'b0);
        use_p <= 1'b1;
        wr(4'h2, 8'h40);
        wr(4'h1, 8'hc3);
        i_partner.exchange(8'h96);
        chk("xch_dut", 8'h96, shift_data);
        chk("xch_far", 8'hc3, rx);
        chk("xch_stat", 8'h40, status);
        chk("xch_buf", 8'h96, shift_buf);
        // reversed edges: shift happens on the rising edge
        cfg(2'h1, 1'b1, 1'b1, 1'b0);
        wr(4'h2, 8'h40);
        wr(4'h1, 8'h80);
        i_partner.level(1'b1);
        chk("rise_shift", 8'h00, {shift_data[7:1], 1'b0});
        chk("rise_count", 8'h01, {4'h0, counter});
        i_partner.level(1'b0);
        chk("fall_count", 8'h02, {4'h0, counter});
        @(posedge ref_clk_i);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk("rst_shift", 8'h00, shift_data);
        chk("rst_stat", 8'h00, status);
        chk("rst_buf", 8'h00, shift_buf);
        chk("rst_pins", 8'h01, {6'h0, data_out, sck_oe});
        complete_run();
    end
endmodule
